// [tws_slave.sv]
`timescale 1ns/100ps
// Behaviour
// R1 - slave only: never drives the clock, never starts a transaction
// R2 - host master generates serial clock; data line carries both directions
// R3 - bus idle when clock and data both high
// R4 - only the master makes start and stop conditions
// R5 - start is data falling while clock high
// R6 - stop is data rising while clock high
// R7 - repeated start without stop begins a fresh transaction
// R8 - every byte shifts as eight bits, most significant first
// R9 - each byte is followed by one acknowledge bit period
// R10 - one data bit per serial clock period
// R11 - driver changes data only while clock low
// R12 - first byte bits seven to one are address, bit zero direction
// R13 - select low answers 0x90 write and 0x91 read
// R14 - select high answers 0xBA write and 0xBB read
// R15 - register addresses are always sixteen bits
// R16 - register data exchanged as sixteen-bit quantities
// R17 - order: start, address byte, register address, data, stop
// R18 - later bytes are register address and write data, or read data
// R19 - transmitter releases data in ack period; receiver pulls low
// R20 - internal register address advances by one after each data byte
// R21 - master reads via write address, repeated start, acks, final nack
// R22 - unmatched address gets no ack; bus ignored until next start
// R23 - clock and data inputs synchronised before edge detection
module tws_slave
  import tws_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  // serial bus pins
  input  wire logic        serial_clock_i,
  input  wire logic        serial_data_line_i,
  output logic             serial_data_line_o,
  output logic             serial_data_line_oe_o,
  // address select strap
  input  wire logic        address_select_pin_i,
  // status
  output logic             busy_o,
  output logic [15:0]      reg_addr_o
);
  import tws_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [1:0] sel_sync_r;
  logic       scl_q_r;
  logic       sda_q_r;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      sel_sync_r <= 2'h0;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
    end else if (clk_en_i) begin
      scl_sync_r <= {scl_sync_r[0], serial_clock_i};      // R23
      sda_sync_r <= {sda_sync_r[0], serial_data_line_i};  // R23
      sel_sync_r <= {sel_sync_r[0], address_select_pin_i};
      scl_q_r    <= scl_sync_r[1];
      sda_q_r    <= sda_sync_r[1];
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl       = scl_sync_r[1];
  assign sda       = sda_sync_r[1];
  assign scl_rise  = scl && !scl_q_r;                     // R10
  assign scl_fall  = !scl && scl_q_r;
  // both conditions need clock high in both samples so a clock edge is not mistaken
  assign start_det = scl && scl_q_r && sda_q_r && !sda;   // R5 R4
  assign stop_det  = scl && scl_q_r && !sda_q_r && sda;   // R6 R4

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  tws_state_t   state_r;
  logic [2:0]   bit_cnt_r;
  logic [7:0]   shift_r;
  logic         first_r;
  logic         rd_r;
  logic         ack_rise_r;
  logic [1:0]   addr_bytes_r;
  logic [15:0]  reg_addr_r;
  logic         drive_low_r;
  logic         master_ack_r;
  logic [7:0]   mem_rdata;
  tws_mem_req_t mem_req;

  logic [7:0] rx_byte;
  logic       addr_hit;
  assign rx_byte = {shift_r[6:0], sda};

  always_comb begin
    addr_hit = 1'b0;
    if (sel_sync_r[1]) begin
      addr_hit = (rx_byte[7:1] == TWS_ADDR_WR_HI[7:1]);   // R14 R12
    end else begin
      addr_hit = (rx_byte[7:1] == TWS_ADDR_WR_LO[7:1]);   // R13 R12
    end
  end

  // ----------------------------------------------------------------
  // state sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_r <= TWS_IDLE;
    end else if (clk_en_i) begin
      if (start_det) begin
        state_r <= TWS_RX;                                // R7
      end else if (stop_det) begin
        state_r <= TWS_IDLE;                              // R3 R17
      end else begin
        unique case (state_r)
          TWS_IDLE, TWS_IGNORE: begin
            state_r <= state_r;                           // R22
          end
          TWS_RX: begin
            if (scl_rise && bit_cnt_r == TWS_LAST_BIT) begin
              if (first_r && !addr_hit) begin
                state_r <= TWS_IGNORE;                    // R22
              end else begin
                state_r <= TWS_ACK;                       // R9
              end
            end
          end
          TWS_ACK: begin
            // the line is already pulled on the fall that closes the ack period
            if (scl_fall && drive_low_r) begin
              state_r <= rd_r ? TWS_TX : TWS_RX;          // R18
            end
          end
          TWS_TX: begin
            if (scl_rise && bit_cnt_r == TWS_LAST_BIT) begin
              state_r <= TWS_TXACK;                       // R9
            end
          end
          TWS_TXACK: begin
            if (scl_fall && ack_rise_r) begin
              state_r <= master_ack_r ? TWS_TX : TWS_IGNORE;  // R21
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // bit counting and shifting, msb first
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      bit_cnt_r <= TWS_BIT_RST;
      shift_r   <= TWS_BYTE_RST;
    end else if (clk_en_i) begin
      if (start_det || state_r == TWS_ACK || state_r == TWS_TXACK) begin
        bit_cnt_r <= TWS_BIT_RST;
      end else if (scl_rise && (state_r == TWS_RX || state_r == TWS_TX)) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;                    // R8 R10
        shift_r   <= rx_byte;                             // R8
      end
    end
  end

  // ----------------------------------------------------------------
  // transaction context
  // ----------------------------------------------------------------
  logic rx_done;
  logic tx_done;
  assign rx_done = state_r == TWS_RX && scl_rise && bit_cnt_r == TWS_LAST_BIT;
  assign tx_done = state_r == TWS_TX && scl_rise && bit_cnt_r == TWS_LAST_BIT;

  // first byte after a start carries the address and the direction
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      first_r <= 1'b1;
      rd_r    <= 1'b0;
    end else if (clk_en_i) begin
      if (start_det) begin
        first_r <= 1'b1;                                  // R7
      end else if (rx_done) begin
        first_r <= 1'b0;
        if (first_r) begin
          rd_r <= rx_byte[TWS_DIR_BIT];                   // R12
        end
      end
    end
  end

  // register address: high byte first, then one step per data byte moved;
  // a restart keeps the address, so a read can follow a bare address write
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      addr_bytes_r <= 2'h0;
      reg_addr_r   <= TWS_REG_ADDR_RST;
    end else if (clk_en_i) begin
      if (start_det) begin
        addr_bytes_r <= 2'h0;
      end else if (rx_done && !first_r) begin
        if (addr_bytes_r != TWS_ADDR_BYTES) begin
          reg_addr_r   <= {reg_addr_r[7:0], rx_byte};     // R15
          addr_bytes_r <= addr_bytes_r + 2'h1;
        end else begin
          reg_addr_r <= reg_addr_r + 16'h0001;            // R20 R16
        end
      end else if (tx_done) begin
        reg_addr_r <= reg_addr_r + 16'h0001;              // R20 R16
      end
    end
  end

  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  // write data go to the store once the register address is complete
  always_comb begin
    mem_req.wr   = clk_en_i && rx_done && !first_r && addr_bytes_r == TWS_ADDR_BYTES;  // R18
    mem_req.addr = reg_addr_r[TWS_MEM_AW-1:0];
    mem_req.data = rx_byte;
  end

  tws_mem u_mem (
    .clock_i  (clock_i),
    .clk_en_i (clk_en_i),
    .req_i    (mem_req),
    .rdata_o  (mem_rdata)
  );

  // ----------------------------------------------------------------
  // master answer to read data
  // ----------------------------------------------------------------
  // sampled on the clock rise of the ack period; the flag tells the fall that
  // opens the period, where the line must be let go, from the one that closes it
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      master_ack_r <= 1'b0;
      ack_rise_r   <= 1'b0;
    end else if (clk_en_i) begin
      if (start_det || state_r != TWS_TXACK) begin
        ack_rise_r <= 1'b0;
      end else if (scl_rise) begin
        master_ack_r <= !sda;                             // R21
        ack_rise_r   <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // data line driver
  // ----------------------------------------------------------------
  // updates only on the falling clock so the line is steady while clock is high
  logic tx_bit;
  assign tx_bit = mem_rdata[TWS_LAST_BIT - bit_cnt_r];

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      drive_low_r <= 1'b0;
    end else if (clk_en_i) begin
      if (start_det || stop_det) begin
        drive_low_r <= 1'b0;
      end else if (scl_fall) begin                        // R11
        unique case (state_r)
          TWS_ACK:   drive_low_r <= drive_low_r ? (rd_r && !mem_rdata[TWS_LAST_BIT]) : 1'b1;  // R19
          TWS_TX:    drive_low_r <= (bit_cnt_r != TWS_BIT_RST) ? !tx_bit : 1'b0;
          TWS_TXACK: drive_low_r <= ack_rise_r && master_ack_r && !mem_rdata[TWS_LAST_BIT];  // R19
          default:   drive_low_r <= 1'b0;                 // R22
        endcase
      end
    end
  end

  // open-drain: only ever pull low, clock is never driven
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      serial_data_line_o <= 1'b0;
    end else if (clk_en_i) begin
      serial_data_line_o <= 1'b0;                         // R1
    end
  end
  assign serial_data_line_oe_o = drive_low_r;             // R2

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      busy_o     <= 1'b0;
      reg_addr_o <= TWS_REG_ADDR_RST;
    end else if (clk_en_i) begin
      busy_o     <= state_r != TWS_IDLE;
      reg_addr_o <= reg_addr_r;
    end
  end
endmodule

// [tws_pkg.sv]
package tws_pkg;

  // ----------------------------------------------------------------
  // address bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] TWS_ADDR_WR_LO = 8'h90;
  localparam logic [7:0] TWS_ADDR_RD_LO = 8'h91;
  localparam logic [7:0] TWS_ADDR_WR_HI = 8'hBA;
  localparam logic [7:0] TWS_ADDR_RD_HI = 8'hBB;

  // ----------------------------------------------------------------
  // field positions and counts
  // ----------------------------------------------------------------
  localparam int         TWS_DIR_BIT    = 0;
  localparam logic [2:0] TWS_LAST_BIT   = 3'h7;
  localparam logic [1:0] TWS_ADDR_BYTES = 2'h2;
  localparam int         TWS_MEM_AW     = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TWS_REG_ADDR_RST = 16'h0000;
  localparam logic [7:0]  TWS_BYTE_RST     = 8'h00;
  localparam logic [2:0]  TWS_BIT_RST      = 3'h0;

  typedef enum logic [2:0] {
    TWS_IDLE,
    TWS_RX,
    TWS_ACK,
    TWS_TX,
    TWS_TXACK,
    TWS_IGNORE
  } tws_state_t;

  // pad view of the open-drain data line
  typedef struct packed {
    logic out;
    logic oe;
  } tws_pad_t;

  // byte-wide access to the register store
  typedef struct packed {
    logic                  wr;
    logic [TWS_MEM_AW-1:0] addr;
    logic [7:0]            data;
  } tws_mem_req_t;

endpackage

// [tws_mem.sv]
`timescale 1ns/100ps
module tws_mem
  import tws_pkg::*;
(
  // clock
  input  wire logic                   clock_i,
  input  wire logic                   clk_en_i,
  // access
  input  wire tws_pkg::tws_mem_req_t  req_i,
  output logic [7:0]                  rdata_o
);
  logic [7:0] mem [0:(1<<TWS_MEM_AW)-1];

  // read data registered; no reset so this maps onto plain ram
  always_ff @(posedge clock_i) begin
    if (clk_en_i) begin
      if (req_i.wr) begin
        mem[req_i.addr] <= req_i.data;
      end
      rdata_o <= mem[req_i.addr];
    end
  end
endmodule

// [tws_slave_sva.sv]
`timescale 1ns/100ps
module tws_slave_chk (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic        clk_en_i,
  // pins
  input wire logic        serial_clock_i,
  input wire logic        serial_data_line_i,
  input wire logic        serial_data_line_o,
  input wire logic        serial_data_line_oe_o,
  input wire logic        address_select_pin_i,
  // status
  input wire logic        busy_o,
  input wire logic [15:0] reg_addr_o
);
  default clocking @(posedge clock_i); endclocking
  // a frozen block sees nothing on the pins, so its answers are not owed then
  default disable iff (!reset_n_i || !clk_en_i);
  sequence s_start;
    serial_clock_i && $past(serial_clock_i) && $fell(serial_data_line_i);
  endsequence
  sequence s_stop;
    serial_clock_i && $past(serial_clock_i) && $rose(serial_data_line_i);
  endsequence
  a_open_drain: assert property (serial_data_line_o == 1'b0)
    else $error("data pin driven high");
  a_reset_clear: assert property ($rose(reset_n_i) |-> !serial_data_line_oe_o && !busy_o && reg_addr_o == 16'h0000)
    else $error("outputs not cleared by reset");
  a_start_busy: assert property (s_start |-> ##[1:6] busy_o)
    else $error("start not taken");
  a_stop_idle: assert property (s_stop |-> ##[1:6] !busy_o)
    else $error("stop did not end transfer");
  a_drive_clk_low: assert property ($changed(serial_data_line_oe_o) |-> !serial_clock_i && !$past(serial_clock_i, 2))
    else $error("data drive changed near clock high");
  a_ack_hold: assert property ($rose(serial_data_line_oe_o) |=> serial_data_line_oe_o[*8])
    else $error("pull-down too short");
  a_idle_quiet: assert property (!busy_o && !$past(busy_o) |-> !serial_data_line_oe_o)
    else $error("line pulled while idle");
  a_addr_hold: assert property (!busy_o && !$past(busy_o) |-> $stable(reg_addr_o))
    else $error("address moved while idle");
endmodule

bind tws_slave tws_slave_chk chk_i (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
  .serial_clock_i(serial_clock_i), .serial_data_line_i(serial_data_line_i),
  .serial_data_line_o(serial_data_line_o), .serial_data_line_oe_o(serial_data_line_oe_o),
  .address_select_pin_i(address_select_pin_i), .busy_o(busy_o), .reg_addr_o(reg_addr_o)
);

// [tws_host.sv]
`timescale 1ns/100ps
// ----------------------------------------
// host master: 40 clocks per bit, idle high
// ----------------------------------------
module tws_host (
  // clock
  input  wire logic clock_i,
  // bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic h(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic bit_out(input logic b);
    sda_low_o <= !b;
    h(10);
    scl_o <= 1'b1;
    h(20);
    scl_o <= 1'b0;
    h(10);
  endtask
  task automatic bit_in(output logic b);
    sda_low_o <= 1'b0;
    h(10);
    scl_o <= 1'b1;
    h(10);
    b = sda_i;
    h(10);
    scl_o <= 1'b0;
    h(10);
  endtask
  task automatic start(input logic rep);
    if (rep) begin
      sda_low_o <= 1'b0;
      h(10);
      scl_o <= 1'b1;
      h(20);
    end
    sda_low_o <= 1'b1;
    h(20);
    scl_o <= 1'b0;
    h(10);
  endtask
  task automatic stop();
    sda_low_o <= 1'b1;
    h(10);
    scl_o <= 1'b1;
    h(20);
    sda_low_o <= 1'b0;
    h(20);
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_in(a);
    ack = !a;
  endtask
  task automatic rd(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_in(b[i]);
    bit_out(!ack);
  endtask
endmodule

// [tb.sv]
`timescale 1ns/100ps
module tb;
  import tws_pkg::*;
  logic        clock;
  logic        reset_n;
  logic        clk_en;
  logic        sel;
  logic        scl;
  logic        host_low;
  logic        dout;
  logic        oe;
  logic        busy;
  logic [15:0] reg_addr;
  wire         sda;
  int          failures;
  int          checked;
  // open-drain line with pull-up
  assign sda = ~host_low & ~(oe & ~dout);
  always #2 clock = ~clock;
  tws_slave uut (
    .clock_i(clock), .reset_n_i(reset_n), .clk_en_i(clk_en),
    .serial_clock_i(scl), .serial_data_line_i(sda),
    .serial_data_line_o(dout), .serial_data_line_oe_o(oe),
    .address_select_pin_i(sel), .busy_o(busy), .reg_addr_o(reg_addr)
  );
  tws_host host (.clock_i(clock), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic send(input logic [7:0] b);
    logic a;
    host.wr(b, a);
    chk("ack", a, 1'b1);
  endtask
  // write a word, then read it back through a repeated start
  task automatic t_rw(input logic s, input logic [15:0] a, input logic [15:0] d);
    logic [7:0] wa;
    logic [7:0] r0;
    logic [7:0] r1;
    wa = s ? TWS_ADDR_WR_HI : TWS_ADDR_WR_LO;
    sel <= s;
    host.h(8);
    host.start(1'b0);
    send(wa);
    send(a[15:8]);
    send(a[7:0]);
    send(d[15:8]);
    send(d[7:0]);
    host.stop();
    chk("reg_addr", reg_addr, a + 16'h0002);
    chk("busy", busy, 1'b0);
    host.start(1'b0);
    send(wa);
    send(a[15:8]);
    send(a[7:0]);
    host.start(1'b1);
    send(wa | 8'h01);
    host.rd(1'b1, r0);
    host.rd(1'b0, r1);
    chk("rdata", {r0, r1}, d);
    host.stop();
  endtask
  // clock enable low: a start and a stop on the pins go unseen
  task automatic t_freeze();
    logic [15:0] ra;
    ra = reg_addr;
    clk_en <= 1'b0;
    host.start(1'b0);
    chk("frozen_busy", busy, 1'b0);
    host.stop();
    chk("frozen_addr", reg_addr, ra);
    clk_en <= 1'b1;
    host.h(8);
    chk("thawed_busy", busy, 1'b0);
  endtask
  // address bytes of the other pair, both directions
  task automatic t_miss();
    logic [7:0]  wa;
    logic        a;
    logic [15:0] ra;
    for (int i = 0; i < 4; i++) begin
      sel <= i[1];
      host.h(8);
      ra = reg_addr;
      wa = i[1] ? (TWS_ADDR_WR_LO | i[0]) : (TWS_ADDR_WR_HI | i[0]);
      host.start(1'b0);
      host.wr(wa, a);
      chk("nack_addr", a, 1'b0);
      host.wr(8'h00, a);
      chk("nack_ignored", a, 1'b0);
      host.stop();
      chk("addr_kept", reg_addr, ra);
    end
  endtask
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    sel = 1'b0;
    failures = 0;
    checked = 0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    t_rw(1'b0, 16'h0002, 16'hABCD);
    t_rw(1'b1, 16'h0105, 16'h1234);
    t_freeze();
    t_miss();
    stop_test();
  end
  // about four times the expected run
  initial begin
    #200000;
    failures++;
    stop_test();
  end
endmodule
